// ### inc/suspend_map.svh
// register offsets, field positions, reset values and timing counts of the suspend block
`ifndef SUSPEND_MAP_SVH
`define SUSPEND_MAP_SVH

`define NUM_PORTS        4
`define PIDX_W           2
`define PORT_LAST_VALID  5'h1a
`define PORT_NODE_SET    5'h1f
`define REG_STATUS       3'h0
`define REG_STATUS_ALT   3'h1
`define REG_CTL_SET      3'h2
`define REG_CTL_CLEAR    3'h3
`define TYPE_READ        6'h00
`define TYPE_WRITE       6'h01
`define TYPE_RESPONSE    6'h3f
`define CTL_SUSPEND_BIT  1
`define CTL_DISABLE_BIT  2
`define CTL_RESET        8'h00
`define NODE_REG_ID      3'h0
`define NODE_REG_PORTS   3'h1
`define HOLD_CLKS        8192
`define HOLD_W           14

`endif

// ### inc/suspend_pkg.sv
// types shared by the suspend-entry design
package suspend_pkg;
    typedef logic [7:0] byte_type;
    typedef enum logic [2:0] {
        INI_IDLE,
        INI_ARB,
        INI_BCAST,
        INI_WAIT_TX,
        INI_DATA_END,
        INI_RESET,
        INI_NOTIFY
    } ini_state_type;
endpackage

// ### inc/alt_mem_if.sv
// carrier between the register logic and the alternate-status memory
`timescale 1ns/1ps
`default_nettype none
`include "suspend_map.svh"
interface alt_mem_if;
    logic                       wr_en;
    logic [`PIDX_W-1:0]         wr_addr;
    suspend_pkg::byte_type      wr_data;
    logic [`PIDX_W-1:0]         rd_addr;
    suspend_pkg::byte_type      rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ### rtl/hold_timer.sv
// hold interval counter restarted by a start pulse
`timescale 1ns/1ps
`default_nettype none
`include "suspend_map.svh"
module hold_timer #(
    parameter logic [`HOLD_W-1:0] HOLD = `HOLD_W'(`HOLD_CLKS)
) (
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   start,
    output logic        busy,
    output logic        done
);
    logic [`HOLD_W-1:0] cnt_q;

    // count down from HOLD; done pulses in the last cycle of the interval
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= HOLD;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - `HOLD_W'(1);
        end
    end

    assign busy = (cnt_q != '0);
    assign done = (cnt_q == `HOLD_W'(1));
endmodule // hold_timer
`default_nettype wire

// ### rtl/alt_status_mem.sv
// per-port alternate status bytes written by the local link, registered read
`timescale 1ns/1ps
`default_nettype none
`include "suspend_map.svh"
module alt_status_mem (
    input  wire logic   clk,
    alt_mem_if.mem      bus
);
    suspend_pkg::byte_type mem_q [`NUM_PORTS];

    // storage and registered read port
    always_ff @(posedge clk) begin
        if (bus.wr_en) begin
            mem_q[bus.wr_addr] <= bus.wr_data;
        end
        bus.rd_data <= mem_q[bus.rd_addr];
    end
endmodule // alt_status_mem
`default_nettype wire

// ### rtl/phy_port_suspend_entry.sv
// per-port suspend entry and extended register access of a serial-bus phy
`timescale 1ns/1ps
`default_nettype none
`include "suspend_map.svh"
module phy_port_suspend_entry #(
    parameter int unsigned HOLD_CLKS = `HOLD_CLKS
) (
    input  wire logic                   I_CLOCK,
    input  wire logic                   I_RST,
    input  wire logic [5:0]             I_NODE_ID,
    input  wire logic                   I_PKT_VALID,
    input  wire logic [5:0]             I_PKT_PHY_ID,
    input  wire logic [5:0]             I_PKT_TYPE,
    input  wire logic [4:0]             I_PKT_PORT,
    input  wire logic [2:0]             I_PKT_REG,
    input  wire logic [7:0]             I_PKT_VALUE,
    input  wire logic                   I_PKT_FROM_LINK,
    input  wire logic                   I_LINK_WR,
    input  wire logic [4:0]             I_LINK_PORT,
    input  wire logic [7:0]             I_LINK_DATA,
    input  wire logic                   I_TX_DONE,
    input  wire logic                   I_ARB_GRANT,
    input  wire logic [`NUM_PORTS-1:0]  I_BIAS_LOW,
    input  wire logic [`NUM_PORTS-1:0]  I_VSENSE,
    output logic                        O_RSP_VALID,
    output logic [5:0]                  O_RSP_PHY_ID,
    output logic [5:0]                  O_RSP_TYPE,
    output logic [4:0]                  O_RSP_PORT,
    output logic [2:0]                  O_RSP_REG,
    output logic [7:0]                  O_RSP_VALUE,
    output logic                        O_ARB_REQ,
    output logic                        O_BCAST_VALID,
    output logic [5:0]                  O_BCAST_PHY_ID,
    output logic [4:0]                  O_BCAST_PORT,
    output logic [7:0]                  O_BCAST_VALUE,
    output logic [`NUM_PORTS-1:0]       O_DATA_END,
    output logic [`NUM_PORTS-1:0]       O_SHORT_RESET,
    output logic [`NUM_PORTS-1:0]       O_NOTIFY_B,
    output logic [`NUM_PORTS-1:0]       O_BIAS_OUT,
    output logic [`NUM_PORTS-1:0]       O_BIAS_OE,
    output logic [`NUM_PORTS-1:0]       O_DISCONNECT,
    output logic [`NUM_PORTS-1:0]       O_RESUME,
    output logic [`NUM_PORTS-1:0]       O_LINK_PRESENT
);
    localparam logic [`HOLD_W-1:0] HOLD = `HOLD_W'(HOLD_CLKS);

    suspend_pkg::ini_state_type     state_q;
    suspend_pkg::ini_state_type     state_d;
    logic [`PIDX_W-1:0]             ini_q;
    logic                           tmr_done;
    logic [`NUM_PORTS-1:0]          susp_v;
    logic [`NUM_PORTS-1:0]          dis_v;
    logic [`NUM_PORTS-1:0]          con_v;
    logic [`NUM_PORTS-1:0]          enter_v;
    logic [`NUM_PORTS-1:0]          active_v;
    suspend_pkg::byte_type          ctl_arr [`NUM_PORTS];
    suspend_pkg::byte_type          st_arr [`NUM_PORTS];
    logic                           p1_valid_q;
    logic [4:0]                     p1_port_q;
    logic [2:0]                     p1_reg_q;
    logic                           rsp_valid_q;
    logic [4:0]                     rsp_port_q;
    logic [2:0]                     rsp_reg_q;
    suspend_pkg::byte_type          rsp_value_q;
    logic [5:0]                     rsp_id_q;
    logic [`NUM_PORTS-1:0]          data_end_q;
    logic [`NUM_PORTS-1:0]          short_reset_q;
    logic [5:0]                     bcast_id_q;
    logic                           bcast_q;

    alt_mem_if amem ();

    alt_status_mem u_alt (
        .clk (I_CLOCK),
        .bus (amem.mem)
    );

    // packet decode: only own-id read or write packets count
    wire pkt_ours  = I_PKT_VALID && (I_PKT_PHY_ID == I_NODE_ID)
                     && ((I_PKT_TYPE == `TYPE_READ) || (I_PKT_TYPE == `TYPE_WRITE));
    wire pkt_wr    = pkt_ours && (I_PKT_TYPE == `TYPE_WRITE);
    wire pkt_port  = (I_PKT_PORT < 5'(`NUM_PORTS));
    wire [`PIDX_W-1:0] pkt_idx = I_PKT_PORT[`PIDX_W-1:0];
    wire pkt_set   = pkt_wr && pkt_port && (I_PKT_REG == `REG_CTL_SET);
    wire pkt_clr   = pkt_wr && pkt_port && (I_PKT_REG == `REG_CTL_CLEAR);

    // suspend selection through a set write with the suspend bit
    wire sel_req   = pkt_set && I_PKT_VALUE[`CTL_SUSPEND_BIT];
    wire sel_ok    = sel_req && !susp_v[pkt_idx] && !dis_v[pkt_idx]
                     && (state_q == suspend_pkg::INI_IDLE);
    wire sel_link  = I_PKT_FROM_LINK;

    // link writes to alternate status go to the memory; packets never write status
    assign amem.wr_en   = I_LINK_WR && (I_LINK_PORT < 5'(`NUM_PORTS));
    assign amem.wr_addr = I_LINK_PORT[`PIDX_W-1:0];
    assign amem.wr_data = I_LINK_DATA;
    assign amem.rd_addr = pkt_idx;

    // notification interval timer
    hold_timer #(
        .HOLD (HOLD)
    ) u_notify_tmr (
        .clk   (I_CLOCK),
        .rst   (I_RST),
        .start (state_q == suspend_pkg::INI_RESET),
        .busy  (),
        .done  (tmr_done)
    );

    wire notify_on = (state_q == suspend_pkg::INI_NOTIFY);
    wire notify_to = notify_on && tmr_done && !susp_v[ini_q] && !enter_v[ini_q];

    // per-port control, status, bias and sense handling
    for (genvar i = 0; i < `NUM_PORTS; i++) begin : g_port
        suspend_pkg::byte_type  ctl_q;
        suspend_pkg::byte_type  ctl_d;
        logic                   con_q;
        logic                   con_d;
        logic                   low_q;
        logic                   prev_bias_q;
        logic                   prev_sense_q;
        logic                   low_done;
        logic                   disc_q;
        logic                   res_q;

        wire sel_me  = (pkt_idx == `PIDX_W'(i));
        wire wr_set  = pkt_set && sel_me;
        wire wr_clr  = pkt_clr && sel_me;
        wire susp    = ctl_q[`CTL_SUSPEND_BIT];
        wire dis     = ctl_q[`CTL_DISABLE_BIT];
        wire parked  = susp && !low_q;
        wire enter   = I_BIAS_LOW[i] && !prev_bias_q && !susp && !dis;
        wire to_me   = notify_to && (ini_q == `PIDX_W'(i));
        wire disc    = parked && I_VSENSE[i] && !prev_sense_q;
        wire conn    = parked && !I_VSENSE[i] && prev_sense_q && !dis;

        // bias-low interval timer
        hold_timer #(
            .HOLD (HOLD)
        ) u_low_tmr (
            .clk   (I_CLOCK),
            .rst   (I_RST),
            .start (enter),
            .busy  (),
            .done  (low_done)
        );

        // control byte: software first, hardware events win
        always_comb begin
            ctl_d = ctl_q;
            if (wr_set) begin
                ctl_d = ctl_q | (I_PKT_VALUE & ~(8'h01 << `CTL_SUSPEND_BIT));
            end else if (wr_clr) begin
                ctl_d = ctl_q & ~I_PKT_VALUE;
            end
            if (enter || to_me) begin
                ctl_d[`CTL_SUSPEND_BIT] = 1'b1;
            end
            if (to_me) begin
                ctl_d[`CTL_DISABLE_BIT] = I_VSENSE[i];
            end
            if (disc && dis) begin
                ctl_d[`CTL_DISABLE_BIT] = 1'b0;
            end
        end

        // link presence follows sense while active, events while suspended
        always_comb begin
            con_d = con_q;
            if (enter || to_me) begin
                con_d = 1'b0;
            end else if (disc) begin
                con_d = 1'b0;
            end else if (conn) begin
                con_d = 1'b1;
            end else if (!susp) begin
                con_d = !I_VSENSE[i];
            end
        end

        always_ff @(posedge I_CLOCK) begin
            if (I_RST) begin
                ctl_q <= `CTL_RESET;
                con_q <= 1'b0;
            end else begin
                ctl_q <= ctl_d;
                con_q <= con_d;
            end
        end

        // bias-low phase and edge history
        always_ff @(posedge I_CLOCK) begin
            if (I_RST) begin
                low_q        <= 1'b0;
                prev_bias_q  <= 1'b0;
                prev_sense_q <= 1'b0;
            end else begin
                low_q        <= enter || (low_q && !low_done);
                prev_bias_q  <= I_BIAS_LOW[i];
                prev_sense_q <= I_VSENSE[i];
            end
        end

        // one-cycle disconnect and resume indications
        always_ff @(posedge I_CLOCK) begin
            if (I_RST) begin
                disc_q <= 1'b0;
                res_q  <= 1'b0;
            end else begin
                disc_q <= disc;
                res_q  <= conn;
            end
        end

        assign susp_v[i]     = susp;
        assign dis_v[i]      = dis;
        assign con_v[i]      = con_q;
        assign enter_v[i]    = enter;
        assign active_v[i]   = con_q && !susp;
        assign ctl_arr[i]    = ctl_q;
        assign st_arr[i]     = {4'h0, I_VSENSE[i], dis, susp, con_q};
        assign O_BIAS_OE[i]  = !parked;
        assign O_BIAS_OUT[i] = !low_q && !susp;
        assign O_DISCONNECT[i] = disc_q;
        assign O_RESUME[i]   = res_q;
        assign O_NOTIFY_B[i] = notify_on && (ini_q == `PIDX_W'(i)) && !susp;
    end

    assign O_LINK_PRESENT = con_v;

    // initiator sequence
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            suspend_pkg::INI_IDLE: begin
                if (sel_ok) begin
                    state_d = sel_link ? suspend_pkg::INI_ARB
                                       : suspend_pkg::INI_WAIT_TX;
                end
            end
            suspend_pkg::INI_ARB: begin
                if (I_ARB_GRANT) begin
                    state_d = suspend_pkg::INI_BCAST;
                end
            end
            suspend_pkg::INI_BCAST: begin
                state_d = suspend_pkg::INI_WAIT_TX;
            end
            suspend_pkg::INI_WAIT_TX: begin
                if (I_TX_DONE) begin
                    state_d = suspend_pkg::INI_DATA_END;
                end
            end
            suspend_pkg::INI_DATA_END: begin
                state_d = suspend_pkg::INI_RESET;
            end
            suspend_pkg::INI_RESET: begin
                state_d = suspend_pkg::INI_NOTIFY;
            end
            suspend_pkg::INI_NOTIFY: begin
                if (susp_v[ini_q] || tmr_done) begin
                    state_d = suspend_pkg::INI_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            state_q <= suspend_pkg::INI_IDLE;
            ini_q   <= '0;
        end else begin
            state_q <= state_d;
            ini_q   <= sel_ok ? pkt_idx : ini_q;
        end
    end

    // sequence pulses: data end to all active, short reset to the active ports other than the initiator, or other than the entering port on a bias-low entry
    wire [`NUM_PORTS-1:0] ini_onehot = `NUM_PORTS'(1) << ini_q;
    wire [`NUM_PORTS-1:0] dend_d = (state_q == suspend_pkg::INI_DATA_END)
                                   ? active_v : '0;
    wire [`NUM_PORTS-1:0] seq_rst = (state_q == suspend_pkg::INI_RESET)
                                    ? (active_v & ~ini_onehot) : '0;
    wire [`NUM_PORTS-1:0] loss_rst = (|enter_v) ? (active_v & ~enter_v) : '0;

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            data_end_q    <= '0;
            short_reset_q <= '0;
        end else begin
            data_end_q    <= dend_d;
            short_reset_q <= (seq_rst | loss_rst) & active_v;
        end
    end

    assign O_DATA_END    = data_end_q;
    assign O_SHORT_RESET = short_reset_q;

    // broadcast of the link-started selection
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            bcast_q    <= 1'b0;
            bcast_id_q <= '0;
        end else begin
            bcast_q    <= (state_q == suspend_pkg::INI_ARB) && I_ARB_GRANT;
            bcast_id_q <= I_NODE_ID;
        end
    end

    assign O_ARB_REQ      = (state_q == suspend_pkg::INI_ARB);
    assign O_BCAST_VALID  = bcast_q;
    assign O_BCAST_PHY_ID = bcast_id_q;
    assign O_BCAST_PORT   = {{(5-`PIDX_W){1'b0}}, ini_q};
    assign O_BCAST_VALUE  = 8'h01 << `CTL_SUSPEND_BIT;

    // response stage 1: capture the request while the memory reads
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            p1_valid_q <= 1'b0;
            p1_port_q  <= '0;
            p1_reg_q   <= '0;
        end else begin
            p1_valid_q <= pkt_ours;
            p1_port_q  <= I_PKT_PORT;
            p1_reg_q   <= I_PKT_REG;
        end
    end

    // response value selection
    wire [`PIDX_W-1:0] p1_idx = p1_port_q[`PIDX_W-1:0];
    wire p1_is_port = (p1_port_q < 5'(`NUM_PORTS));
    wire p1_is_node = (p1_port_q == `PORT_NODE_SET);
    wire [7:0] node_val = (p1_reg_q == `NODE_REG_ID)    ? {I_NODE_ID, 2'b00} :
                          (p1_reg_q == `NODE_REG_PORTS) ? 8'(`NUM_PORTS) : 8'h00;
    wire [7:0] port_val = (p1_reg_q == `REG_STATUS)     ? st_arr[p1_idx] :
                          (p1_reg_q == `REG_STATUS_ALT) ? amem.rd_data :
                          (p1_reg_q == `REG_CTL_SET)    ? ctl_arr[p1_idx] :
                          (p1_reg_q == `REG_CTL_CLEAR)  ? ctl_arr[p1_idx] : 8'h00;
    wire [7:0] rsp_val  = p1_is_node ? node_val :
                          p1_is_port ? port_val : 8'h00;

    // response stage 2: registered answer
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            rsp_valid_q <= 1'b0;
            rsp_id_q    <= '0;
            rsp_port_q  <= '0;
            rsp_reg_q   <= '0;
            rsp_value_q <= '0;
        end else begin
            rsp_valid_q <= p1_valid_q;
            rsp_id_q    <= I_NODE_ID;
            rsp_port_q  <= p1_port_q;
            rsp_reg_q   <= p1_reg_q;
            rsp_value_q <= rsp_val;
        end
    end

    assign O_RSP_VALID  = rsp_valid_q;
    assign O_RSP_PHY_ID = rsp_id_q;
    assign O_RSP_TYPE   = `TYPE_RESPONSE;
    assign O_RSP_PORT   = rsp_port_q;
    assign O_RSP_REG    = rsp_reg_q;
    assign O_RSP_VALUE  = rsp_value_q;
endmodule // phy_port_suspend_entry
`default_nettype wire

// ### tb/phy_port_suspend_entry_sva.sv
// assertions on the suspend-entry ports
`timescale 1ns/1ps
`default_nettype none
`include "suspend_map.svh"
module phy_port_suspend_entry_sva #(
    parameter int unsigned HOLD_CLKS = 16
) (
    input wire logic       I_CLOCK,
    input wire logic       I_RST,
    input wire logic [5:0] I_NODE_ID,
    input wire logic       I_PKT_VALID,
    input wire logic [5:0] I_PKT_PHY_ID,
    input wire logic [5:0] I_PKT_TYPE,
    input wire logic [4:0] I_PKT_PORT,
    input wire logic [2:0] I_PKT_REG,
    input wire logic       I_ARB_GRANT,
    input wire logic [3:0] I_VSENSE,
    input wire logic       O_RSP_VALID,
    input wire logic [5:0] O_RSP_PHY_ID,
    input wire logic [5:0] O_RSP_TYPE,
    input wire logic [4:0] O_RSP_PORT,
    input wire logic [2:0] O_RSP_REG,
    input wire logic [7:0] O_RSP_VALUE,
    input wire logic       O_ARB_REQ,
    input wire logic       O_BCAST_VALID,
    input wire logic [5:0] O_BCAST_PHY_ID,
    input wire logic [7:0] O_BCAST_VALUE,
    input wire logic [3:0] O_DATA_END,
    input wire logic [3:0] O_SHORT_RESET,
    input wire logic [3:0] O_NOTIFY_B,
    input wire logic [3:0] O_BIAS_OUT,
    input wire logic [3:0] O_BIAS_OE,
    input wire logic [3:0] O_DISCONNECT,
    input wire logic [3:0] O_LINK_PRESENT
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    // packet decode and low-drive on port 0
    wire take = I_PKT_VALID && I_PKT_PHY_ID == I_NODE_ID && I_PKT_TYPE[5:1] == 5'h00;
    wire node = I_PKT_PORT == `PORT_NODE_SET;
    wire bad  = !node && (I_PKT_PORT > `PORT_LAST_VALID || I_PKT_REG > 3'h3);
    wire low0 = O_BIAS_OE[0] & ~O_BIAS_OUT[0];
    logic [15:0] low_q, ntf_q;
    // run lengths of the low-drive and notify intervals
    always_ff @(posedge I_CLOCK) begin
        low_q <= (I_RST || !low0) ? 16'h0 : low_q + 16'h1;
        ntf_q <= (I_RST || !(|O_NOTIFY_B)) ? 16'h0 : ntf_q + 16'h1;
    end
    sequence s_dend_notify;
        (|O_DATA_END) ##1 (|O_NOTIFY_B);
    endsequence
    property p_rsp_lat;
        take |-> ##2 O_RSP_VALID && O_RSP_TYPE == `TYPE_RESPONSE
            && O_RSP_PHY_ID == $past(I_NODE_ID, 2) && O_RSP_PORT == $past(I_PKT_PORT, 2)
            && O_RSP_REG == $past(I_PKT_REG, 2);
    endproperty
    property p_rsp_cause;
        O_RSP_VALID |-> $past(take, 2);
    endproperty
    property p_bad_zero;
        take && bad |-> ##2 O_RSP_VALUE == 8'h00;
    endproperty
    property p_node_id;
        take && node && I_PKT_REG == `NODE_REG_ID |-> ##2 O_RSP_VALUE == {$past(I_NODE_ID, 2), 2'b00};
    endproperty
    property p_bcast;
        O_ARB_REQ && I_ARB_GRANT |-> ##[1:2] O_BCAST_VALID && O_BCAST_VALUE == 8'h02
            && O_BCAST_PHY_ID == I_NODE_ID;
    endproperty
    property p_quiet;
        (~O_BIAS_OE & (O_SHORT_RESET | O_NOTIFY_B | O_DATA_END)) == 4'h0;
    endproperty
    property p_notify_seq;
        |O_DATA_END |-> s_dend_notify ##0 ((O_NOTIFY_B & O_SHORT_RESET) == 4'h0
            && (O_SHORT_RESET | O_NOTIFY_B) == $past(O_DATA_END));
    endproperty
    property p_notify_len;
        ntf_q <= 16'(HOLD_CLKS);
    endproperty
    property p_low_len;
        $fell(low0) |-> low_q == 16'(HOLD_CLKS) && !O_BIAS_OE[0];
    endproperty
    property p_disc;
        !O_BIAS_OE[0] && $rose(I_VSENSE[0]) |=> O_DISCONNECT[0] && !O_LINK_PRESENT[0];
    endproperty
    property p_lp_clear;
        $fell(O_BIAS_OUT[0]) && O_BIAS_OE[0] |-> !O_LINK_PRESENT[0];
    endproperty
    a_rsp_lat: assert property (p_rsp_lat) else $error("response late or wrong fields");
    a_rsp_cause: assert property (p_rsp_cause) else $error("response without packet");
    a_bad_zero: assert property (p_bad_zero) else $error("invalid place not zero");
    a_node_id: assert property (p_node_id) else $error("node id register wrong");
    a_bcast: assert property (p_bcast) else $error("broadcast missing after grant");
    a_quiet: assert property (p_quiet) else $error("suspended port signalling");
    a_notify_seq: assert property (p_notify_seq) else $error("notify order wrong");
    a_notify_len: assert property (p_notify_len) else $error("notify held too long");
    a_low_len: assert property (p_low_len) else $error("low bias interval wrong");
    a_disc: assert property (p_disc) else $error("disconnect not reported");
    a_lp_clear: assert property (p_lp_clear) else $error("link present kept");
endmodule // phy_port_suspend_entry_sva
bind phy_port_suspend_entry phy_port_suspend_entry_sva #(.HOLD_CLKS(HOLD_CLKS)) chk (.*);
`default_nettype wire

// ### tb/peer_port_model.sv
// far-end peer port and cable
`timescale 1ns/1ps
`default_nettype none
module peer_port_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_notify,
    input  wire logic       i_wake,
    input  wire logic       i_answer,
    input  wire logic [7:0] i_lag,
    input  wire logic       i_plugged,
    output logic            o_bias_low,
    output logic            o_vsense
);
    logic [7:0] wait_q;
    // drop bias after the lag until woken
    always_ff @(posedge i_clk) begin
        if (i_rst || i_wake) begin
            wait_q     <= 8'h00;
            o_bias_low <= 1'b0;
        end else if (i_notify && i_answer) begin
            wait_q <= wait_q + 8'h01;
            if (wait_q == i_lag) begin
                o_bias_low <= 1'b1;
            end
        end else begin
            wait_q <= 8'h00;
        end
    end
    // sense reads low while the cable joins both ports
    assign o_vsense = ~i_plugged;
endmodule // peer_port_model
`default_nettype wire

// ### tb/phy_port_suspend_entry_bench.sv
// self-checking bench for the suspend-entry block
`timescale 1ns/1ps
`default_nettype none
`include "suspend_map.svh"
module phy_port_suspend_entry_bench;
    localparam logic [5:0] NODE = 6'h05;
    logic       clk = 1'b0, rst = 1'b1, pv = 1'b0, plink = 1'b0, lwr = 1'b0;
    logic       txd = 1'b0, gnt = 1'b0;
    logic [5:0] pid = 6'h00, ptyp = 6'h00;
    logic [4:0] pport = 5'h00, lport = 5'h00;
    logic [2:0] preg = 3'h0;
    logic [7:0] pval = 8'h00, ldata = 8'h00;
    logic [3:0] plug = 4'hf, ans = 4'h1;
    int         bad_count = 0, num_checks = 0;
    wire        rv, arq, bcv;
    wire  [7:0] rval;
    wire  [4:0] bport;
    wire  [3:0] dend, srst, ntf, bout, boe, disc, res, lp, blow, vs;
    wire  [8:0] ev = {rv, ~boe[1], ~boe[0], ~bout[0] & boe[0], |res, |disc, |srst, bcv, |dend};
    always #20 clk = ~clk;
    phy_port_suspend_entry #(.HOLD_CLKS(16)) uut (
        .I_CLOCK(clk), .I_RST(rst), .I_NODE_ID(NODE), .I_PKT_VALID(pv), .I_PKT_PHY_ID(pid),
        .I_PKT_TYPE(ptyp), .I_PKT_PORT(pport), .I_PKT_REG(preg), .I_PKT_VALUE(pval),
        .I_PKT_FROM_LINK(plink), .I_LINK_WR(lwr), .I_LINK_PORT(lport), .I_LINK_DATA(ldata),
        .I_TX_DONE(txd), .I_ARB_GRANT(gnt), .I_BIAS_LOW(blow), .I_VSENSE(vs),
        .O_RSP_VALID(rv), .O_RSP_PHY_ID(), .O_RSP_TYPE(), .O_RSP_PORT(), .O_RSP_REG(),
        .O_RSP_VALUE(rval), .O_ARB_REQ(arq), .O_BCAST_VALID(bcv), .O_BCAST_PHY_ID(),
        .O_BCAST_PORT(bport), .O_BCAST_VALUE(), .O_DATA_END(dend), .O_SHORT_RESET(srst),
        .O_NOTIFY_B(ntf), .O_BIAS_OUT(bout), .O_BIAS_OE(boe), .O_DISCONNECT(disc),
        .O_RESUME(res), .O_LINK_PRESENT(lp));
    // one peer port on each cable
    for (genvar g = 0; g < 4; g++) begin : peer
        peer_port_model pm (.i_clk(clk), .i_rst(rst), .i_notify(ntf[g]), .i_wake(res[g]),
            .i_answer(ans[g]), .i_lag(8'h03), .i_plugged(plug[g]), .o_bias_low(blow[g]),
            .o_vsense(vs[g]));
    end
    task automatic check(input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // bounded wait for one event line, then compare
    task automatic wait_ev(input int k, input int lim, input logic exp);
        int n = 0;
        @(negedge clk);
        while (ev[k] !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        check({7'h00, ev[k]}, {7'h00, exp});
    endtask
    task automatic send(input logic [5:0] id, input logic [5:0] t, input logic [4:0] p,
                        input logic [2:0] r, input logic [7:0] v, input logic lk);
        @(posedge clk);
        {pv, pid, ptyp, pport, preg, pval, plink} <= {1'b1, id, t, p, r, v, lk};
        @(posedge clk);
        pv <= 1'b0;
    endtask
    task automatic acc(input logic [5:0] t, input logic [4:0] p, input logic [2:0] r,
                       input logic [7:0] v, input logic [7:0] exp);
        send(NODE, t, p, r, v, 1'b0);
        wait_ev(8, 6, 1'b1);
        check(rval, exp);
    endtask
    task automatic pulse_tx;
        @(posedge clk);
        txd <= 1'b1;
        @(posedge clk);
        txd <= 1'b0;
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int p = 0; p < 4; p++) acc(`TYPE_READ, 5'(p), `REG_CTL_SET, 8'h00, 8'h00);
        acc(`TYPE_READ, `PORT_NODE_SET, `NODE_REG_ID, 8'h00, {NODE, 2'b00});
        acc(`TYPE_WRITE, `PORT_NODE_SET, `NODE_REG_PORTS, 8'hff, 8'h04);
        for (int p = 27; p < 31; p++) acc(`TYPE_READ, 5'(p), `REG_CTL_SET, 8'h00, 8'h00);
        acc(`TYPE_READ, 5'h00, 3'h6, 8'h00, 8'h00);
        send(6'h2a, `TYPE_READ, 5'h00, `REG_CTL_SET, 8'h00, 1'b0);
        wait_ev(8, 6, 1'b0);
        send(NODE, 6'h02, 5'h00, `REG_CTL_SET, 8'h00, 1'b0);
        wait_ev(8, 6, 1'b0);
        @(posedge clk);
        {lwr, lport, ldata} <= {1'b1, 5'h01, 8'h5a};
        @(posedge clk);
        lwr <= 1'b0;
        acc(`TYPE_WRITE, 5'h01, `REG_STATUS_ALT, 8'hff, 8'h5a);
        acc(`TYPE_WRITE, 5'h01, `REG_STATUS, 8'hff, 8'h01);
        acc(`TYPE_WRITE, 5'h03, `REG_CTL_SET, 8'h04, 8'h04);
        acc(`TYPE_WRITE, 5'h03, `REG_CTL_SET, 8'h02, 8'h04);
        wait_ev(0, 10, 1'b0);
        acc(`TYPE_WRITE, 5'h03, `REG_CTL_CLEAR, 8'h04, 8'h00);
        acc(`TYPE_WRITE, 5'h00, `REG_CTL_SET, 8'h02, 8'h00);
        pulse_tx;
        wait_ev(0, 8, 1'b1);
        check({4'h0, dend}, 8'h0f);
        @(negedge clk);
        check({4'h0, srst}, 8'h0e);
        @(negedge clk);
        check({4'h0, ntf}, 8'h01);
        wait_ev(2, 12, 1'b1);
        check({4'h0, srst}, 8'h0e);
        wait_ev(5, 4, 1'b1);
        acc(`TYPE_READ, 5'h00, `REG_STATUS, 8'h00, 8'h02);
        acc(`TYPE_WRITE, 5'h00, `REG_CTL_SET, 8'h02, 8'h02);
        wait_ev(0, 6, 1'b0);
        wait_ev(6, 40, 1'b1);
        plug[0] <= 1'b0;
        wait_ev(3, 4, 1'b1);
        plug[0] <= 1'b1;
        wait_ev(4, 4, 1'b1);
        check({4'h0, lp}, 8'h0f);
        send(NODE, `TYPE_WRITE, 5'h01, `REG_CTL_SET, 8'h02, 1'b1);
        @(negedge clk);
        check({7'h00, arq}, 8'h01);
        @(posedge clk);
        gnt <= 1'b1;
        @(posedge clk);
        gnt <= 1'b0;
        wait_ev(1, 4, 1'b1);
        check({3'h0, bport}, 8'h01);
        pulse_tx;
        repeat (6) @(posedge clk);
        plug[1] <= 1'b0;
        wait_ev(7, 40, 1'b1);
        acc(`TYPE_READ, 5'h01, `REG_STATUS, 8'h00, 8'h0e);
        plug[1] <= 1'b1;
        wait_ev(4, 6, 1'b0);
        plug[1] <= 1'b0;
        wait_ev(3, 6, 1'b1);
        acc(`TYPE_READ, 5'h01, `REG_STATUS, 8'h00, 8'h0a);
        plug[1] <= 1'b1;
        wait_ev(4, 6, 1'b1);
        test_done;
    end
    // watchdog against a hang
    initial begin
        repeat (4000) @(posedge clk);
        bad_count++;
        test_done;
    end
endmodule // phy_port_suspend_entry_bench
`default_nettype wire
